// File: core/ulm_pkg.sv
// constants, modes and carrier types of the upstream lane map and hot-plug control
// assumes a single 25 MHz clock shared by all users
package ulm_pkg;
	localparam int LANE_W = 10;
	localparam int NUM_LANES = 4;
	localparam int FIFO_DEPTH = 4;
	localparam int EDID_AW = 9;
	localparam logic [19:0] ADDR_SINK_COUNT = 20'h0_0200;
	localparam logic [19:0] ADDR_LINK_PWR = 20'h0_0600;
	localparam logic [19:0] ADDR_TRAIN_SET = 20'h0_0102;
	localparam logic [19:0] ADDR_LANE_STAT = 20'h0_0202;
	localparam logic [7:0] PWR_ON_VAL = 8'h01;
	localparam logic [7:0] PWR_DOWN_VAL = 8'h02;
	localparam logic [7:0] TP_NONE = 8'h00;
	localparam logic [7:0] TP_TPS1 = 8'h01;
	localparam logic [7:0] TP_TPS4 = 8'h07;
	localparam logic [6:0] I2C_EDID_DEV = 7'h50;
	localparam logic [6:0] I2C_SEG_DEV = 7'h30;
	localparam int CLK_MHZ = 25;
	localparam int IRQ_MIN_US = 500;
	localparam int IRQ_CYCLES = IRQ_MIN_US * CLK_MHZ;
	typedef enum logic [2:0] {
		MAP_STD, MAP_STRAIGHT_DP, MAP_STRAIGHT_DP_USB, MAP_FLIPPED_DP_ONLY, MAP_FLIPPED_DP_USB
	} ulm_map_t;
	typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_READ, ST_REPLY} ulm_state_t;
	typedef logic [NUM_LANES-1:0][LANE_W-1:0] ulm_lanes_t;
	typedef struct packed {
		logic i2c;
		logic wr;
		logic [19:0] addr;
		logic [7:0] data;
	} ulm_req_t;
	typedef struct packed {
		logic ack;
		logic [7:0] data;
	} ulm_rsp_t;
endpackage

// File: core/ulm_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes depth is a power of two
module ulm_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic inValid,
	output logic inReady,
	input wire logic [W-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [W-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW:0] wr_q;
	logic [AW:0] rd_q;
	wire push = inValid && inReady;
	wire pop = outValid && outReady;
	assign inReady = (wr_q ^ rd_q) != {1'b1, {AW{1'b0}}};
	assign outValid = wr_q != rd_q;
	assign outData = mem[rd_q[AW-1:0]];
	always_ff @(posedge clk) begin
		if (!rstn) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push) wr_q <= wr_q + 1'b1;
			if (pop) rd_q <= rd_q + 1'b1;
		end
	end
	always_ff @(posedge clk) begin
		if (push) mem[wr_q[AW-1:0]] <= inData;
	end
endmodule

// File: core/ulm_edid_mem.sv
// display identification store, one write port and one registered read port
// assumes the downstream side loads it before the source reads it
module ulm_edid_mem
	import ulm_pkg::*;
(
	input wire logic clk,
	input wire logic wrEn,
	input wire logic [EDID_AW-1:0] wrAddr,
	input wire logic [7:0] wrData,
	input wire logic [EDID_AW-1:0] rdAddr,
	output logic [7:0] rdData
);
	logic [7:0] mem [2**EDID_AW];
	always_ff @(posedge clk) begin
		if (wrEn) mem[wrAddr] <= wrData;
		rdData <= mem[rdAddr];
	end
endmodule

// File: core/ufp_lane_map_hpd_control.sv
// upstream receive port control: lane map, sideband register access, training, hot-plug
// assumes lane symbols and lane status come from logic on clk; hot-plug and power pins do not
// Behaviour
// - the connector lanes and sideband pair are mapped for a plain or a reversible connector.
// - straight takes lanes 2,3,0,1, flipped takes 1,0,3,2 with swapped sideband, mixed gives a pair to USB.
// - native and I2C-over-channel requests are both accepted and answered.
// - identification data is read over I2C with a segment pointer beyond 256 bytes.
// - training with pattern sequence 4 is supported.
// - after 02h is written to the power register a full new training is needed.
// - under the alternate-mode policy the lane count shrinks to 4, 2, 1 or 0: the most lanes from lane 0 up that all have clock recovery done.
// - the upstream hot-plug output is high while the device is not powered off and no interrupt pulse is running.
// - the sink count reads 1 while downstream hot-plug is high and 0 while it is low.
// - a downstream hot-plug change while not powered off gives a hot-plug interrupt pulse upstream; all changes during one pulse give one further pulse.
module ufp_lane_map_hpd_control
	import ulm_pkg::*;
#(
	parameter int IRQ_CYC = IRQ_CYCLES
) (
	input wire logic clk,
	input wire logic rstn,
	input wire ulm_map_t mapMode,
	input wire logic altModePolicy,
	input wire ulm_lanes_t pinLanes,
	input wire logic pinAuxP,
	input wire logic pinAuxN,
	output ulm_lanes_t rxLanes,
	output logic rxAuxP,
	output logic rxAuxN,
	output logic [LANE_W-1:0] usbRx,
	output logic [LANE_W-1:0] usbTx,
	input wire logic [NUM_LANES-1:0] crDone,
	output logic [2:0] activeLaneCount,
	output logic [7:0] trainPattern,
	output logic linkTrained,
	input wire logic reqValid,
	output logic reqReady,
	input wire ulm_req_t req,
	output logic rspValid,
	input wire logic rspReady,
	output ulm_rsp_t rsp,
	input wire logic edidWrEn,
	input wire logic [EDID_AW-1:0] edidWrAddr,
	input wire logic [7:0] edidWrData,
	input wire logic downstream_hotplug_in,
	input wire logic powerOff,
	output logic upstream_hotplug_out
);
	// lane mapping
	localparam logic [LANE_W-1:0] LZ = '0;
	wire logic isFlip = mapMode == MAP_FLIPPED_DP_ONLY || mapMode == MAP_FLIPPED_DP_USB;
	wire logic isMixed = mapMode == MAP_STRAIGHT_DP_USB || mapMode == MAP_FLIPPED_DP_USB;
	wire ulm_lanes_t mapStraight = {pinLanes[1], pinLanes[0], pinLanes[3], pinLanes[2]};
	wire ulm_lanes_t mapStrUsb = {LZ, LZ, pinLanes[3], pinLanes[2]};
	wire ulm_lanes_t mapFlip = {pinLanes[2], pinLanes[3], pinLanes[0], pinLanes[1]};
	wire ulm_lanes_t mapFlipUsb = {LZ, LZ, pinLanes[0], pinLanes[1]};
	wire ulm_lanes_t lanesD = mapMode == MAP_STRAIGHT_DP ? mapStraight :
		mapMode == MAP_STRAIGHT_DP_USB ? mapStrUsb :
		mapMode == MAP_FLIPPED_DP_ONLY ? mapFlip :
		mapMode == MAP_FLIPPED_DP_USB ? mapFlipUsb : pinLanes;
	wire logic [LANE_W-1:0] usbRxD = mapMode == MAP_STRAIGHT_DP_USB ? pinLanes[0] :
		mapMode == MAP_FLIPPED_DP_USB ? pinLanes[3] : LZ;
	wire logic [LANE_W-1:0] usbTxD = mapMode == MAP_STRAIGHT_DP_USB ? pinLanes[1] :
		mapMode == MAP_FLIPPED_DP_USB ? pinLanes[2] : LZ;
	wire logic [2:0] laneCntD = !altModePolicy ? (isMixed ? 3'd2 : 3'd4) :
		(!isMixed && &crDone) ? 3'd4 :
		&crDone[1:0] ? 3'd2 :
		crDone[0] ? 3'd1 : 3'd0;
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rxLanes <= '0;
			rxAuxP <= 1'b0;
			rxAuxN <= 1'b0;
			usbRx <= '0;
			usbTx <= '0;
			activeLaneCount <= 3'd0;
		end else begin
			rxLanes <= lanesD;
			rxAuxP <= isFlip ? pinAuxN : pinAuxP;
			rxAuxN <= isFlip ? pinAuxP : pinAuxN;
			usbRx <= usbRxD;
			usbTx <= usbTxD;
			activeLaneCount <= laneCntD;
		end
	end

	// request buffer and transaction sequencer
	ulm_req_t fifoOut;
	ulm_req_t req_q;
	ulm_state_t state_q;
	ulm_state_t state_d;
	logic fifoValid;
	wire logic popReq = state_q == ST_IDLE && fifoValid;
	ulm_fifo #(.W($bits(ulm_req_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.rstn(rstn),
		.inValid(reqValid),
		.inReady(reqReady),
		.inData(req),
		.outValid(fifoValid),
		.outReady(popReq),
		.outData(fifoOut)
	);
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: if (fifoValid) state_d = ST_EXEC;
			ST_EXEC: state_d = ST_READ;
			ST_READ: state_d = ST_REPLY;
			ST_REPLY: if (rspReady) state_d = ST_IDLE;
			default: state_d = ST_IDLE;
		endcase
	end
	assign rspValid = state_q == ST_REPLY;

	// decode
	logic hpdS1;
	logic hpdS2;
	logic pwrS1;
	logic pwrS2;
	logic [7:0] linkPwr_q;
	logic [7:0] seg_q;
	logic [7:0] offset_q;
	logic trainSeen_q;
	logic [7:0] memRdData;
	wire logic exec = state_q == ST_EXEC;
	wire logic natWr = exec && !req_q.i2c && req_q.wr;
	wire logic [6:0] i2cDev = req_q.addr[6:0];
	wire logic i2cEdid = req_q.i2c && i2cDev == I2C_EDID_DEV;
	wire logic i2cSeg = req_q.i2c && i2cDev == I2C_SEG_DEV;
	wire logic wrPwr = natWr && req_q.addr == ADDR_LINK_PWR;
	wire logic wrTrain = natWr && req_q.addr == ADDR_TRAIN_SET;
	wire logic powerDown = wrPwr && req_q.data == PWR_DOWN_VAL;
	wire logic [3:0] laneMask = activeLaneCount == 3'd4 ? 4'hF :
		activeLaneCount == 3'd2 ? 4'h3 :
		activeLaneCount == 3'd1 ? 4'h1 : 4'h0;
	wire logic crOk = laneMask != 4'h0 && (crDone & laneMask) == laneMask;
	wire logic trainEnd = wrTrain && req_q.data == TP_NONE && trainSeen_q && crOk
		&& linkPwr_q != PWR_DOWN_VAL;
	wire logic [7:0] natRd = req_q.addr == ADDR_SINK_COUNT ? {7'h00, hpdS2} :
		req_q.addr == ADDR_LINK_PWR ? linkPwr_q :
		req_q.addr == ADDR_TRAIN_SET ? trainPattern :
		req_q.addr == ADDR_LANE_STAT ? {4'h0, crDone} : 8'h00;
	wire logic i2cAck = i2cEdid || (i2cSeg && req_q.wr);
	wire logic edidRdDone = state_q == ST_READ && i2cEdid && !req_q.wr;

	ulm_edid_mem u_edid (
		.clk(clk),
		.wrEn(edidWrEn),
		.wrAddr(edidWrAddr),
		.wrData(edidWrData),
		.rdAddr({seg_q[0], offset_q}),
		.rdData(memRdData)
	);

	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_q <= ST_IDLE;
			req_q <= '0;
			rsp <= '0;
		end else begin
			state_q <= state_d;
			if (popReq) req_q <= fifoOut;
			if (state_q == ST_READ) begin
				rsp.ack <= req_q.i2c ? i2cAck : 1'b1;
				rsp.data <= req_q.wr ? 8'h00 : req_q.i2c ? (i2cEdid ? memRdData : 8'h00) : natRd;
			end
		end
	end

	// identification pointer, power state, training
	always_ff @(posedge clk) begin
		if (!rstn) begin
			seg_q <= 8'h00;
			offset_q <= 8'h00;
			linkPwr_q <= PWR_ON_VAL;
			trainPattern <= TP_NONE;
			trainSeen_q <= 1'b0;
			linkTrained <= 1'b0;
		end else begin
			if (exec && i2cSeg && req_q.wr) seg_q <= req_q.data;
			if (exec && i2cEdid && req_q.wr) offset_q <= req_q.data;
			else if (edidRdDone) offset_q <= offset_q + 8'h01;
			if (wrPwr) linkPwr_q <= req_q.data;
			if (wrTrain) trainPattern <= req_q.data;
			if (powerDown) begin
				trainSeen_q <= 1'b0;
				linkTrained <= 1'b0;
			end else if (wrTrain && req_q.data == TP_TPS1) begin
				trainSeen_q <= 1'b1;
				linkTrained <= 1'b0;
			end else if (trainEnd) begin
				trainSeen_q <= 1'b0;
				linkTrained <= 1'b1;
			end
		end
	end

	// hot-plug: pin synchronisers, change detect, interrupt pulse
	logic hpdPrev_q;
	logic pend_q;
	logic irqActive_q;
	logic [15:0] irqCnt_q;
	wire logic hpdChange = hpdS2 ^ hpdPrev_q;
	wire logic irqStart = (pend_q || hpdChange) && !irqActive_q && !pwrS2;
	wire logic irqLast = irqCnt_q == 16'(IRQ_CYC - 1);
	wire logic irqActiveD = irqStart || (irqActive_q && !irqLast && !pwrS2);
	always_ff @(posedge clk) begin
		if (!rstn) begin
			hpdS1 <= 1'b0;
			hpdS2 <= 1'b0;
			pwrS1 <= 1'b1;
			pwrS2 <= 1'b1;
			hpdPrev_q <= 1'b0;
			pend_q <= 1'b0;
			irqActive_q <= 1'b0;
			irqCnt_q <= 16'h0000;
			upstream_hotplug_out <= 1'b0;
		end else begin
			hpdS1 <= downstream_hotplug_in;
			hpdS2 <= hpdS1;
			pwrS1 <= powerOff;
			pwrS2 <= pwrS1;
			hpdPrev_q <= hpdS2;
			pend_q <= hpdChange && irqActive_q ? 1'b1 : (irqStart || pwrS2) ? 1'b0 : pend_q;
			irqActive_q <= irqActiveD;
			irqCnt_q <= irqStart ? 16'h0000 : irqCnt_q + 16'h0001;
			upstream_hotplug_out <= !pwrS2 && !irqActiveD;
		end
	end

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	chk_std_lane_pass: assert property ((mapMode == MAP_STD) |=>
		rxLanes == $past(pinLanes)) else $error("standard map not pass-through");
	chk_straight_lane_order: assert property ((mapMode == MAP_STRAIGHT_DP) |=>
		rxLanes[0] == $past(pinLanes[2]) && rxLanes[3] == $past(pinLanes[1]))
		else $error("straight map order wrong");
	chk_flip_aux_swap: assert property ((mapMode == MAP_FLIPPED_DP_ONLY) |=>
		rxLanes[0] == $past(pinLanes[1]) && rxAuxP == $past(pinAuxN))
		else $error("flipped map wrong");
	chk_reply_latency: assert property (exec |-> ##2 rspValid)
		else $error("reply not given two cycles after execution");
	chk_i2c_bad_nack: assert property ((state_q == ST_READ && req_q.i2c && !i2cEdid
		&& !i2cSeg) |=> !rsp.ack) else $error("unknown i2c target acknowledged");
	chk_tps4_accept: assert property ((wrTrain && req_q.data == TP_TPS4) |=>
		trainPattern == TP_TPS4) else $error("pattern 4 not taken");
	chk_power_retrain: assert property (powerDown |=> !linkTrained ##1
		!linkTrained) else $error("link still trained after power down");
	chk_alt_lane_cut: assert property ((altModePolicy && !isMixed
		&& crDone == 4'b0011) |=> activeLaneCount == 3'd2) else $error("lane count not cut");
	chk_sink_count_read: assert property ((state_q == ST_READ && !req_q.i2c
		&& !req_q.wr && req_q.addr == ADDR_SINK_COUNT) |=> rsp.data == {7'h00, $past(hpdS2)})
		else $error("sink count mismatch");
	chk_hpd_stays_high: assert property ((!pwrS2 && !irqActive_q)[*2]
		|-> upstream_hotplug_out) else $error("hot-plug output low while powered");
	chk_irq_follows_change: assert property ((hpdChange && !pwrS2 && !pwrS1
		&& !powerOff) |-> ##[1:3] !upstream_hotplug_out) else $error("no interrupt pulse");
	chk_irq_pulse_width: assert property ($fell(irqActive_q) && !$past(pwrS2) |->
		$past(irqCnt_q) == 16'(IRQ_CYC - 1)) else $error("interrupt pulse width wrong");
	chk_straight_usb_map: assert property ((mapMode == MAP_STRAIGHT_DP_USB) |=>
		usbRx == $past(pinLanes[0]) && usbTx == $past(pinLanes[1]) && rxLanes[3] == LZ)
		else $error("straight usb map wrong");
	chk_flipped_usb_map: assert property ((mapMode == MAP_FLIPPED_DP_USB) |=>
		usbRx == $past(pinLanes[3]) && usbTx == $past(pinLanes[2]) && rxLanes[1] == $past(pinLanes[0]))
		else $error("flipped usb map wrong");
	chk_aux_straight: assert property (!isFlip |=>
		rxAuxP == $past(pinAuxP) && rxAuxN == $past(pinAuxN))
		else $error("sideband pair swapped in straight map");
	chk_mixed_lane_count: assert property ((!altModePolicy && isMixed) |=>
		activeLaneCount == 3'd2) else $error("mixed map lane count wrong");
	chk_alt_full_count: assert property ((altModePolicy && !isMixed && &crDone) |=>
		activeLaneCount == 3'd4) else $error("full lane count not kept");
	chk_seg_read_nack: assert property ((state_q == ST_READ && i2cSeg && !req_q.wr) |=>
		!rsp.ack) else $error("segment read acknowledged");
	chk_rsp_hold: assert property ((rspValid && !rspReady) |=>
		rspValid && $stable(rsp)) else $error("answer dropped before taken");
	chk_seg_write: assert property ((exec && i2cSeg && req_q.wr) |=>
		seg_q == $past(req_q.data)) else $error("segment pointer not written");
	chk_edid_offset_step: assert property (edidRdDone |=>
		offset_q == $past(offset_q) + 8'h01) else $error("offset not advanced");
	chk_power_reg_write: assert property (wrPwr |=>
		linkPwr_q == $past(req_q.data)) else $error("power register not written");
	chk_train_start: assert property ((wrTrain && req_q.data == TP_TPS1) |=>
		!linkTrained) else $error("link trained during new training");
	chk_train_done: assert property (trainEnd |=> linkTrained)
		else $error("training end not taken");
	chk_no_train_unseen: assert property ((wrTrain && req_q.data == TP_NONE && !trainSeen_q
		&& !linkTrained) |=> !linkTrained) else $error("trained without full sequence");
	chk_power_off_low: assert property (pwrS2 |=> !upstream_hotplug_out)
		else $error("hot-plug output high while powered off");
	chk_irq_blocked_off: assert property (pwrS2 |=> !irqActive_q)
		else $error("interrupt pulse while powered off");
	chk_hpd_change_pend: assert property ((hpdChange && irqActive_q) |=> pend_q)
		else $error("change during pulse lost");
	cov_power_off: cover property ($rose(pwrS2));
	cov_flipped_usb: cover property (mapMode == MAP_FLIPPED_DP_USB ##1 rxLanes[0] != LZ);
	cov_edid_read: cover property (edidRdDone && seg_q != 8'h00);
	cov_irq_pulse: cover property ($rose(irqActive_q));
	cov_train_done: cover property ($rose(linkTrained));
endmodule

// File: verification/ulm_src_model.sv
// source model on the sideband request port: requests, answers, training
// assumes the port is sampled on the rising edge and driven here at the falling edge
module ulm_src_model
	import ulm_pkg::*;
(
	input wire logic clk,
	output logic reqValid,
	input wire logic reqReady,
	output ulm_req_t req,
	input wire logic rspValid,
	output logic rspReady,
	input wire ulm_rsp_t rsp
);
	timeunit 1ns;
	timeprecision 1ns;
	int stall = 0;
	int tmo = 0;
	initial begin
		reqValid = 1'b0;
		rspReady = 1'b0;
		req = '0;
	end
	// native or i2c request held until taken
	task automatic send(input logic i2c, input logic wr, input logic [19:0] a,
			input logic [7:0] d);
		int n;
		n = 0;
		@(negedge clk);
		reqValid = 1'b1;
		req = '{i2c, wr, a, d};
		while (!reqReady && n < 50) begin
			@(negedge clk);
			n++;
		end
		tmo += int'(n >= 50);
		@(negedge clk);
		reqValid = 1'b0;
		req = ~req;
	endtask
	// answer taken after an optional stall
	task automatic take(output ulm_rsp_t r);
		int n;
		n = 0;
		while (!rspValid && n < 50) begin
			@(negedge clk);
			n++;
		end
		tmo += int'(n >= 50);
		repeat (stall) @(negedge clk);
		r = rsp;
		rspReady = 1'b1;
		@(negedge clk);
		rspReady = 1'b0;
	endtask
	task automatic xfer(input logic i2c, input logic wr, input logic [19:0] a,
			input logic [7:0] d, output ulm_rsp_t r);
		send(i2c, wr, a, d);
		take(r);
	endtask
	// back-to-back sink count reads until refused
	task automatic burst(output int taken);
		taken = 0;
		@(negedge clk);
		reqValid = 1'b1;
		req = '{1'b0, 1'b0, ADDR_SINK_COUNT, 8'h00};
		while (reqReady && taken < 8) begin
			taken++;
			@(negedge clk);
		end
		reqValid = 1'b0;
		req = ~req;
	endtask
	// full training; without sequence 4 the plain pattern path is used
	task automatic train(input logic tps4);
		ulm_rsp_t r;
		xfer(1'b0, 1'b1, ADDR_TRAIN_SET, TP_TPS1, r);
		if (tps4)
			xfer(1'b0, 1'b1, ADDR_TRAIN_SET, TP_TPS4, r);
		xfer(1'b0, 1'b1, ADDR_TRAIN_SET, TP_NONE, r);
	endtask
endmodule

// File: verification/ufp_lane_map_hpd_control_tb.sv
// self-checking bench of the upstream lane map, sideband access and hot-plug
// assumes the source model drives requests; pulse length shortened to 20 cycles
module ufp_lane_map_hpd_control_tb
	import ulm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int PULSE = 20;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	ulm_map_t mapMode = MAP_STD;
	logic altModePolicy = 1'b0;
	ulm_lanes_t pinLanes = '0;
	logic pinAuxP = 1'b1;
	logic pinAuxN = 1'b0;
	logic [NUM_LANES-1:0] crDone = 4'hf;
	logic edidWrEn = 1'b0;
	logic [EDID_AW-1:0] edidWrAddr = '0;
	logic [7:0] edidWrData = '0;
	logic hpdIn = 1'b0;
	logic powerOff = 1'b0;
	ulm_lanes_t rxLanes;
	logic rxAuxP, rxAuxN, linkTrained, reqValid, reqReady, rspValid, rspReady, hpdOut;
	logic [LANE_W-1:0] usbRx, usbTx;
	logic [2:0] activeLaneCount;
	logic [7:0] trainPattern;
	ulm_req_t req;
	ulm_rsp_t rsp, r;
	int n_fail = 0;
	int samples_checked = 0;
	int taken;
	logic [2:0] mapTab [5][4] = '{'{0, 1, 2, 3}, '{2, 3, 0, 1}, '{2, 3, 4, 4},
		'{1, 0, 3, 2}, '{1, 0, 4, 4}};
	logic [3:0] crTab [5] = '{4'hf, 4'h7, 4'h1, 4'h2, 4'h0};
	logic [2:0] cntTab [5] = '{4, 2, 1, 0, 0};
	logic [8:0] edAddr [3] = '{9'h005, 9'h105, 9'h106};
	always #20 clk = ~clk;
	ufp_lane_map_hpd_control #(.IRQ_CYC(PULSE)) dut_u (.clk(clk), .rstn(rstn),
		.mapMode(mapMode), .altModePolicy(altModePolicy), .pinLanes(pinLanes),
		.pinAuxP(pinAuxP), .pinAuxN(pinAuxN), .rxLanes(rxLanes), .rxAuxP(rxAuxP),
		.rxAuxN(rxAuxN), .usbRx(usbRx), .usbTx(usbTx), .crDone(crDone),
		.activeLaneCount(activeLaneCount), .trainPattern(trainPattern),
		.linkTrained(linkTrained), .reqValid(reqValid), .reqReady(reqReady), .req(req),
		.rspValid(rspValid), .rspReady(rspReady), .rsp(rsp), .edidWrEn(edidWrEn),
		.edidWrAddr(edidWrAddr), .edidWrData(edidWrData), .downstream_hotplug_in(hpdIn),
		.powerOff(powerOff), .upstream_hotplug_out(hpdOut));
	ulm_src_model src_u (.clk(clk), .reqValid(reqValid), .reqReady(reqReady), .req(req),
		.rspValid(rspValid), .rspReady(rspReady), .rsp(rsp));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic io(input logic i2c, input logic wr, input logic [19:0] a,
			input logic [7:0] d, input logic [8:0] exp);
		src_u.xfer(i2c, wr, a, d, r);
		check(r, exp);
	endtask
	task automatic pulse();
		int n;
		int low;
		n = 0;
		low = 0;
		while (hpdOut && n < 10) begin
			@(negedge clk);
			n++;
		end
		while (!hpdOut && low < 100) begin
			@(negedge clk);
			low++;
		end
		check(low, PULSE);
	endtask
	task automatic results();
		n_fail += src_u.tmo;
		$display("checks %0d, failures %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (2) @(negedge clk);
		rstn = 1'b1;
		for (int i = 0; i < 3; i++) begin
			edidWrEn = 1'b1;
			edidWrAddr = edAddr[i];
			edidWrData = edAddr[i][8:1] ^ 8'h3c;
			@(negedge clk);
		end
		edidWrEn = 1'b0;
		check(hpdOut, 1);
		for (int k = 0; k < NUM_LANES; k++)
			pinLanes[k] = 10'h1a0 + LANE_W'(k);
		for (int m = 0; m < 5; m++) begin
			mapMode = ulm_map_t'(m);
			repeat (2) @(negedge clk);
			for (int k = 0; k < NUM_LANES; k++)
				check(rxLanes[k], mapTab[m][k] == 4 ? '0 : pinLanes[mapTab[m][k][1:0]]);
			check({rxAuxP, rxAuxN}, m >= 3 ? 2'b01 : 2'b10);
			check({usbRx, usbTx}, m == 2 ? {pinLanes[0], pinLanes[1]} :
				m == 4 ? {pinLanes[3], pinLanes[2]} : 20'h0_0000);
			check(activeLaneCount, (m == 2 || m == 4) ? 2 : 4);
		end
		mapMode = MAP_STD;
		altModePolicy = 1'b1;
		for (int c = 0; c < 5; c++) begin
			crDone = crTab[c];
			repeat (2) @(negedge clk);
			check(activeLaneCount, cntTab[c]);
		end
		altModePolicy = 1'b0;
		crDone = 4'hf;
		src_u.train(1'b1);
		check(linkTrained, 1);
		io(0, 1, ADDR_TRAIN_SET, TP_TPS4, 9'h100);
		check(trainPattern, TP_TPS4);
		io(0, 0, ADDR_TRAIN_SET, 8'h00, {1'b1, TP_TPS4});
		check(linkTrained, 1);
		io(0, 0, ADDR_LANE_STAT, 8'h00, 9'h10f);
		io(0, 1, ADDR_LINK_PWR, PWR_DOWN_VAL, 9'h100);
		check(linkTrained, 0);
		io(0, 0, ADDR_LINK_PWR, 8'h00, {1'b1, PWR_DOWN_VAL});
		io(0, 1, ADDR_LINK_PWR, PWR_ON_VAL, 9'h100);
		io(0, 1, ADDR_TRAIN_SET, TP_NONE, 9'h100);
		check(linkTrained, 0);
		src_u.train(1'b0);
		check(linkTrained, 1);
		io(1, 1, {13'h0000, I2C_SEG_DEV}, 8'h01, 9'h100);
		io(1, 1, {13'h0000, I2C_EDID_DEV}, 8'h05, 9'h100);
		io(1, 0, {13'h0000, I2C_EDID_DEV}, 8'h00, 9'h1be);
		io(1, 0, {13'h0000, I2C_EDID_DEV}, 8'h00, 9'h1bf);
		io(1, 1, {13'h0000, I2C_SEG_DEV}, 8'h00, 9'h100);
		io(1, 1, {13'h0000, I2C_EDID_DEV}, 8'h05, 9'h100);
		io(1, 0, {13'h0000, I2C_EDID_DEV}, 8'h00, 9'h13e);
		io(1, 0, {13'h0000, 7'h51}, 8'h00, 9'h000);
		io(1, 0, {13'h0000, I2C_SEG_DEV}, 8'h00, 9'h000);
		io(0, 0, 20'h0_0333, 8'h00, 9'h100);
		hpdIn = 1'b1;
		pulse();
		io(0, 0, ADDR_SINK_COUNT, 8'h00, 9'h101);
		hpdIn = 1'b0;
		pulse();
		io(0, 0, ADDR_SINK_COUNT, 8'h00, 9'h100);
		powerOff = 1'b1;
		repeat (4) @(negedge clk);
		hpdIn = 1'b1;
		for (int i = 0; i < 8; i++) begin
			@(negedge clk);
			check(hpdOut, 0);
		end
		powerOff = 1'b0;
		repeat (5) @(negedge clk);
		check(hpdOut, 1);
		src_u.stall = 3;
		src_u.burst(taken);
		check(taken, 1 + FIFO_DEPTH);
		for (int i = 0; i < 1 + FIFO_DEPTH; i++) begin
			src_u.take(r);
			check(r, 9'h101);
		end
		results();
	end
endmodule
